// ===== shared/fut_defs.svh
// register map, field positions, reset values and geometry of the flash user test engine
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
`ifndef FUT_DEFS_SVH
`define FUT_DEFS_SVH

// word indices on the register bus; byte address is four times these
`define FUT_REG_CTRL     3'h0
`define FUT_REG_FDATA    3'h1
`define FUT_REG_SIG0     3'h2
`define FUT_REG_SIG1     3'h3
`define FUT_REG_BSEL     3'h4
`define FUT_REG_STAT     3'h5
`define FUT_REG_WAIT     3'h6

// control register fields
`define FUT_B_DONE       0
`define FUT_B_START      1
`define FUT_B_SEQ        2
`define FUT_B_ECCEN      3
`define FUT_B_MLVL       4
`define FUT_B_MEN        5
`define FUT_SYN_LSB      16
`define FUT_SYN_MSB      22
`define FUT_B_UTE        31
`define FUT_PASSWORD     32'hf9f99999

// status register fields
`define FUT_B_RWE        0
`define FUT_B_BUSY       1

// wait state register fields and reset value
`define FUT_AWS_LSB      0
`define FUT_DWS_LSB      2
`define FUT_WAIT_RST     4'h5

// array geometry
`define FUT_NBLK         4
`define FUT_WBITS        4
`define FUT_ABITS        6

// signature feedback taps
`define FUT_SIGNATURE_ACCUMULATOR_POLY    32'h80200003

`endif

// ===== shared/fut_pkg.sv
// types of the flash user test engine
package fut_pkg;

   // gray codes along idle, addr, data, fold, next
   typedef enum logic [2:0] {
      FUT_IDLE  = 3'h0,
      FUT_ADDR  = 3'h1,
      FUT_DATA  = 3'h3,
      FUT_FOLD  = 3'h2,
      FUT_NEXT  = 3'h6,
      FUT_ECCK  = 3'h7,
      FUT_ABORT = 3'h5
   } fut_state_t;

endpackage : fut_pkg

// ===== shared/fut_ecc_if.sv
// carrier between the test engine and its ECC decoder
`timescale 1ns/100ps
interface fut_ecc_if;
   logic [31:0] data;
   logic [6:0]  check;
   logic [31:0] corrected;
   logic        singleErr;
   logic        doubleErr;

   modport user (output data, output check, input corrected, input singleErr, input doubleErr);
   modport dec  (input data, input check, output corrected, output singleErr, output doubleErr);
endinterface : fut_ecc_if

// ===== hdl/fut_ecc.sv
// SEC-DED decoder: 32 data bits guarded by 7 check bits
`timescale 1ns/100ps
module fut_ecc (
   fut_ecc_if.dec eccBus
);

   // column code of data bit j: the j-th 6-bit value that is not a power of two
   function automatic logic [5:0] colOf(input int j);
      int n;
      int v;
      n = 0;
      colOf = 6'h00;
      for (v = 3; v < 64; v++) begin
         if ((v & (v - 1)) != 0) begin
            if (n == j) begin
               colOf = 6'(v);
            end
            n++;
         end
      end
   endfunction : colOf

   logic [5:0]  syn;
   logic        parErr;

   //------------------------------------------------------------------
   // syndrome, six hamming bits plus overall parity
   //------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_syn
         logic [31:0] mask;
         always_comb begin
            logic [5:0] col;
            col = 6'h00;
            for (int j = 0; j < 32; j++) begin
               col     = colOf(j);
               mask[j] = col[i];
            end
         end
         assign syn[i] = ^(eccBus.data & mask) ^ eccBus.check[i];
      end
      for (i = 0; i < 32; i++) begin : g_fix
         assign eccBus.corrected[i] = eccBus.data[i] ^ (parErr && syn == colOf(i));
      end
   endgenerate

   assign parErr           = ^eccBus.data ^ ^eccBus.check;
   // odd parity error means one flip; even with nonzero syndrome means two
   assign eccBus.singleErr = parErr;
   assign eccBus.doubleErr = !parErr && syn != 6'h00;

endmodule : fut_ecc

// ===== hdl/fut_engine.sv
// flash user test engine: integrity scan, margin read and ECC logic check
`timescale 1ns/100ps
`include "fut_defs.svh"
module fut_engine (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // register bus, Avalon-MM slave
   input  wire logic [2:0]             avsAddress,
   input  wire logic                   avsRead,
   input  wire logic                   avsWrite,
   input  wire logic [31:0]            avsWritedata,
   output logic      [31:0]            avsReaddata,
   output logic                        avsWaitrequest,
   // flash array
   output logic                        arrRead,
   output logic [`FUT_ABITS-1:0]       arrAddr,
   input  wire logic [31:0]            arrData,
   input  wire logic [6:0]             arrCheck,
   output logic                        marginEn,
   output logic                        marginLevel,
   // protection and user access
   input  wire logic [`FUT_NBLK-1:0]   blockLocked,
   input  wire logic                   userRead,
   output logic                        testActive
);

   //------------------------------------------------------------------
   // decode helpers
   //------------------------------------------------------------------
   function automatic logic wordHit(input logic [2:0] a, input logic [2:0] ofs);
      wordHit = (a == ofs);
   endfunction : wordHit

   // internal order reverses word bits inside each block
   function automatic logic [`FUT_ABITS-1:0] physAddr(input logic [`FUT_ABITS-1:0] idx,
                                                      input logic seq);
      physAddr = idx;
      if (!seq) begin
         for (int b = 0; b < `FUT_WBITS; b++) begin
            physAddr[b] = idx[`FUT_WBITS-1-b];
         end
      end
   endfunction : physAddr

   function automatic logic [31:0] misrStep(input logic [31:0] m, input logic [31:0] d);
      misrStep = {m[30:0], 1'b0} ^ (m[31] ? `FUT_SIGNATURE_ACCUMULATOR_POLY : 32'h00000000) ^ d;
   endfunction : misrStep

   //------------------------------------------------------------------
   // declarations
   //------------------------------------------------------------------
   fut_pkg::fut_state_t          state;
   logic                         ack;
   logic                         wrStb;
   logic                         test_enable_bit;
   logic                         start;
   logic                         done;
   logic                         seqAddr;
   logic                         eccEn;
   logic                         mLevel;
   logic                         mEn;
   logic [6:0]                   forcedSyn;
   logic [31:0]                  forcedData;
   logic [31:0]                  sig [2];
   logic [`FUT_NBLK-1:0]         blockSel;
   logic [1:0]                   addrWait;
   logic [1:0]                   dataWait;
   logic                         read_while_write_error_flag;
   logic [`FUT_ABITS-1:0]        idx;
   logic                         pass;
   logic [1:0]                   waitCnt;
   logic                         launch;
   logic                         abortReq;
   logic                         lastIdx;
   logic                         finish;
   logic                         eligible;
   logic                         running;
   logic [`FUT_ABITS-1:0]        curAddr;
   logic [31:0]                  next_rdata;
   logic [31:0]                  ctrlView;
   fut_ecc_if eccBus ();
   fut_ecc fut_ecc_inst (
      .eccBus (eccBus)
   );

   //------------------------------------------------------------------
   // bus handshake: one wait cycle, answer on the second edge
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avsRead || avsWrite) && !ack;
      end
   end

   assign avsWaitrequest = (avsRead || avsWrite) && !ack;
   assign wrStb          = avsWrite && ack;

   //------------------------------------------------------------------
   // control decode
   //------------------------------------------------------------------
   assign running  = (state != fut_pkg::FUT_IDLE);
   assign launch   = wrStb && wordHit(avsAddress, `FUT_REG_CTRL) && test_enable_bit && done && !start
                     && avsWritedata[`FUT_B_START] && avsWritedata[`FUT_B_UTE];
   // abort is taken between words, so an array read is never cut short
   assign abortReq = !start && !done;
   assign lastIdx  = (idx == {`FUT_ABITS{1'b1}});
   assign finish   = (state == fut_pkg::FUT_NEXT && lastIdx && pass)
                     || state == fut_pkg::FUT_ECCK || state == fut_pkg::FUT_ABORT;
   assign curAddr  = physAddr(idx, seqAddr);
   assign eligible = blockSel[curAddr[`FUT_ABITS-1:`FUT_WBITS]]
                     && !blockLocked[curAddr[`FUT_ABITS-1:`FUT_WBITS]];

   //------------------------------------------------------------------
   // control register
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         test_enable_bit <= 1'b0;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_CTRL)) begin
         if (avsWritedata == `FUT_PASSWORD) begin
            test_enable_bit <= 1'b1;
         end else if (test_enable_bit && done) begin
            test_enable_bit <= avsWritedata[`FUT_B_UTE];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         start <= 1'b0;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_CTRL) && test_enable_bit && avsWritedata != `FUT_PASSWORD) begin
         start <= avsWritedata[`FUT_B_START] && avsWritedata[`FUT_B_UTE];
      end
   end

   // hardware set wins; launch is the only clear
   always_ff @(posedge clk) begin
      if (srst) begin
         done <= 1'b1;
      end else if (finish) begin
         done <= 1'b1;
      end else if (launch) begin
         done <= 1'b0;
      end
   end

   // mode fields frozen while a check runs
   always_ff @(posedge clk) begin
      if (srst) begin
         seqAddr   <= 1'b0;
         eccEn     <= 1'b0;
         mLevel    <= 1'b0;
         mEn       <= 1'b0;
         forcedSyn <= 7'h00;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_CTRL) && test_enable_bit && done
                   && avsWritedata != `FUT_PASSWORD) begin
         seqAddr   <= avsWritedata[`FUT_B_SEQ];
         eccEn     <= avsWritedata[`FUT_B_ECCEN];
         mLevel    <= avsWritedata[`FUT_B_MLVL];
         mEn       <= avsWritedata[`FUT_B_MEN];
         forcedSyn <= avsWritedata[`FUT_SYN_MSB:`FUT_SYN_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         forcedData <= 32'h00000000;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_FDATA) && done) begin
         forcedData <= avsWritedata;
      end
   end

   //------------------------------------------------------------------
   // block select, wait states, status
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         blockSel <= '0;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_BSEL) && !running) begin
         blockSel <= avsWritedata[`FUT_NBLK-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         addrWait <= 2'(`FUT_WAIT_RST >> `FUT_AWS_LSB);
         dataWait <= 2'(`FUT_WAIT_RST >> `FUT_DWS_LSB);
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_WAIT) && !running) begin
         addrWait <= avsWritedata[`FUT_AWS_LSB +: 2];
         dataWait <= avsWritedata[`FUT_DWS_LSB +: 2];
      end
   end

   // a user read in test mode in the same cycle as a clear still leaves the flag set
   always_ff @(posedge clk) begin
      if (srst) begin
         read_while_write_error_flag <= 1'b0;
      end else if (userRead && test_enable_bit) begin
         read_while_write_error_flag <= 1'b1;
      end else if (wrStb && wordHit(avsAddress, `FUT_REG_STAT) && avsWritedata[`FUT_B_RWE]) begin
         read_while_write_error_flag <= 1'b0;
      end
   end

   //------------------------------------------------------------------
   // sequencer
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= fut_pkg::FUT_IDLE;
      end else begin
         unique case (state)
            fut_pkg::FUT_IDLE: begin
               if (launch) begin
                  state <= avsWritedata[`FUT_B_ECCEN] || eccEn ? fut_pkg::FUT_ECCK
                                                               : fut_pkg::FUT_ADDR;
               end
            end
            fut_pkg::FUT_ADDR: begin
               if (!eligible) begin
                  state <= fut_pkg::FUT_NEXT;
               end else if (waitCnt == 2'h0) begin
                  state <= fut_pkg::FUT_DATA;
               end
            end
            fut_pkg::FUT_DATA: begin
               if (waitCnt == 2'h0) begin
                  state <= fut_pkg::FUT_FOLD;
               end
            end
            fut_pkg::FUT_FOLD: state <= fut_pkg::FUT_NEXT;
            fut_pkg::FUT_NEXT: begin
               if (abortReq) begin
                  state <= fut_pkg::FUT_ABORT;
               end else if (lastIdx && pass) begin
                  state <= fut_pkg::FUT_IDLE;
               end else begin
                  state <= fut_pkg::FUT_ADDR;
               end
            end
            fut_pkg::FUT_ECCK, fut_pkg::FUT_ABORT: state <= fut_pkg::FUT_IDLE;
            default: state <= fut_pkg::FUT_IDLE;
         endcase
      end
   end

   // two full passes over the address space
   always_ff @(posedge clk) begin
      if (srst || launch) begin
         idx  <= '0;
         pass <= 1'b0;
      end else if (state == fut_pkg::FUT_NEXT) begin
         idx <= idx + 1'b1;
         if (lastIdx) begin
            pass <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         waitCnt <= 2'h0;
      end else if (state == fut_pkg::FUT_IDLE || state == fut_pkg::FUT_NEXT) begin
         waitCnt <= addrWait;
      end else if (state == fut_pkg::FUT_ADDR && waitCnt == 2'h0) begin
         waitCnt <= dataWait;
      end else if (waitCnt != 2'h0) begin
         waitCnt <= waitCnt - 2'h1;
      end
   end

   //------------------------------------------------------------------
   // ECC logic input: array word, or forced values in ECC check
   //------------------------------------------------------------------
   assign eccBus.data  = (state == fut_pkg::FUT_ECCK) ? forcedData : arrData;
   assign eccBus.check = (state == fut_pkg::FUT_ECCK) ? forcedSyn  : arrCheck;

   //------------------------------------------------------------------
   // signature accumulators, one per pass
   //------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_sig
         always_ff @(posedge clk) begin
            if (srst) begin
               sig[k] <= 32'h00000000;
            end else if (wrStb && wordHit(avsAddress, 3'(`FUT_REG_SIG0 + k)) && done) begin
               sig[k] <= avsWritedata;
            end else if (state == fut_pkg::FUT_FOLD && pass == 1'(k)) begin
               // raw data and check bits, flags from the decoder
               sig[k] <= misrStep(sig[k], (k == 0) ? arrData
                         : {23'h000000, eccBus.doubleErr, eccBus.singleErr, arrCheck});
            end else if (state == fut_pkg::FUT_ECCK) begin
               sig[k] <= (k == 0) ? eccBus.corrected
                         : {23'h000000, eccBus.doubleErr, eccBus.singleErr, forcedSyn};
            end
         end
      end
   endgenerate

   //------------------------------------------------------------------
   // array and pin outputs
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         arrRead <= 1'b0;
         arrAddr <= '0;
      end else begin
         arrRead <= (state == fut_pkg::FUT_ADDR && eligible) || state == fut_pkg::FUT_DATA;
         arrAddr <= curAddr;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         marginEn    <= 1'b0;
         marginLevel <= 1'b0;
         testActive  <= 1'b0;
      end else begin
         marginEn    <= test_enable_bit && mEn;
         marginLevel <= test_enable_bit && mEn && mLevel;
         testActive  <= test_enable_bit;
      end
   end

   //------------------------------------------------------------------
   // read data; mode fields, forced data and signatures read as zero while done is low
   //------------------------------------------------------------------
   always_comb begin
      ctrlView                  = 32'h00000000;
      ctrlView[`FUT_B_UTE]      = test_enable_bit;
      ctrlView[`FUT_B_START]    = start;
      ctrlView[`FUT_B_DONE]     = done;
      if (done) begin
         ctrlView[`FUT_B_SEQ]                    = seqAddr;
         ctrlView[`FUT_B_ECCEN]                  = eccEn;
         ctrlView[`FUT_B_MLVL]                   = mLevel;
         ctrlView[`FUT_B_MEN]                    = mEn;
         ctrlView[`FUT_SYN_MSB:`FUT_SYN_LSB]     = forcedSyn;
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      unique case (avsAddress)
         `FUT_REG_CTRL:  next_rdata = ctrlView;
         `FUT_REG_FDATA: next_rdata = done ? forcedData : 32'h00000000;
         `FUT_REG_SIG0:  next_rdata = done ? sig[0] : 32'h00000000;
         `FUT_REG_SIG1:  next_rdata = done ? sig[1] : 32'h00000000;
         `FUT_REG_BSEL:  next_rdata = {24'h000000, blockLocked, blockSel};
         `FUT_REG_STAT:  next_rdata = {30'h00000000, running, read_while_write_error_flag};
         `FUT_REG_WAIT:  next_rdata = {28'h0000000, dataWait, addrWait};
         default:        next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         avsReaddata <= 32'h00000000;
      end else if (avsRead && !ack) begin
         avsReaddata <= next_rdata;
      end
   end

endmodule : fut_engine

// ===== test/fut_engine_sva.sv
// port assertions of the flash user test engine
`timescale 1ns/100ps
`include "fut_defs.svh"
module fut_engine_sva (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   srst,
   // register bus
   input wire logic                   avsRead,
   input wire logic                   avsWrite,
   input wire logic [31:0]            avsReaddata,
   input wire logic                   avsWaitrequest,
   // array and protection
   input wire logic                   arrRead,
   input wire logic [`FUT_ABITS-1:0]  arrAddr,
   input wire logic                   marginEn,
   input wire logic [`FUT_NBLK-1:0]   blockLocked,
   input wire logic                   testActive
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (srst);
   // ----
   // word read at reset wait settings: one address wait, two data cycles, fold
   // ----
   sequence s_word;
      arrRead[*4] ##1 !arrRead;
   endsequence
   property p_wait; (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest; endproperty
   property p_rd; !(avsRead && avsWaitrequest) |=> $stable(avsReaddata); endproperty
   property p_len; $rose(arrRead) |-> s_word; endproperty
   property p_addr; arrRead && $past(arrRead) |-> $stable(arrAddr); endproperty
   property p_lock; arrRead |-> !blockLocked[arrAddr[5:4]]; endproperty
   property p_act; arrRead |-> testActive; endproperty
   property p_mrg; arrRead && $past(arrRead) |-> $stable(marginEn); endproperty
   property p_rst; disable iff (1'b0) srst |=> !testActive && !arrRead && !marginEn; endproperty
   a_wait: assert property (p_wait) else $error("wait state not one cycle");
   a_rd:   assert property (p_rd) else $error("read data moved without a read");
   a_len:  assert property (p_len) else $error("array read length off");
   a_addr: assert property (p_addr) else $error("address moved inside a read");
   a_lock: assert property (p_lock) else $error("locked block read");
   a_act:  assert property (p_act) else $error("array read outside test mode");
   a_mrg:  assert property (p_mrg) else $error("margin changed inside a read");
   a_rst:  assert property (p_rst) else $error("reset state wrong");
endmodule : fut_engine_sva

// ===== test/fut_flash_model.sv
// flash array with check bits, seen from the engine
`timescale 1ns/100ps
`include "fut_defs.svh"
module fut_flash_model (
   // clock
   input wire logic                   clk,
   // array port
   input wire logic                   arrRead,
   input wire logic [`FUT_ABITS-1:0]  arrAddr,
   output logic     [31:0]            arrData,
   output logic     [6:0]             arrCheck
);
   logic [31:0] lastData = 32'h0;
   function automatic logic [31:0] fut_word(input logic [5:0] a);
      return {2{a, 10'h2b5}};
   endfunction : fut_word
   always @(posedge clk) if (arrRead) lastData <= fut_word(arrAddr);
   // released lines show the inverse so a stale sample cannot match
   assign arrData  = arrRead ? fut_word(arrAddr) : ~lastData;
   assign arrCheck = arrRead ? {1'b0, arrAddr} ^ 7'h55 : ~lastData[6:0];
endmodule : fut_flash_model

// ===== test/flash_user_test_signature_accumulator_engine_bench.sv
// self-checking bench of the flash user test engine
`timescale 1ns/100ps
`include "fut_defs.svh"
module flash_user_test_signature_accumulator_engine_bench;
   logic        clk = 1'b0, srst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, userRead = 1'b0;
   logic        avsWaitrequest, testActive, arrRead, marginEn, marginLevel;
   logic [2:0]  avsAddress = 3'h0;
   logic [31:0] avsWritedata = 32'h0, avsReaddata, arrData, rdv, b;
   logic [6:0]  arrCheck;
   logic [5:0]  arrAddr;
   logic [3:0]  blockLocked = 4'h1;
   int          fails = 0, n_compared = 0;
   always #4 clk = ~clk;
   fut_engine fut_engine_inst (.clk, .srst, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsReaddata,
      .avsWaitrequest, .arrRead, .arrAddr, .arrData, .arrCheck, .marginEn, .marginLevel, .blockLocked,
      .userRead, .testActive);
   fut_flash_model fut_flash_model_inst (.clk, .arrRead, .arrAddr, .arrData, .arrCheck);
   task automatic tally_and_finish;
      $display("compared %0d wrong %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      if (n == 20) begin
         fails++;
         $display("wrong value at %0t: no answer on the register bus", $time);
      end
      rdv = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : bus
   task automatic waitdone(input int lim);
      int k;
      k = 0;
      do begin
         bus(0, `FUT_REG_CTRL, 0);
         k++;
      end while (rdv[0] !== 1'b1 && k < lim);
      chk({31'h0, rdv[0]}, 32'h1);
   endtask : waitdone
   // internal order reverses the word bits inside block 1
   function automatic logic [31:0] expsig(input logic s);
      logic [31:0] m;
      logic [3:0]  w;
      m = 32'h0;
      for (int i = 0; i < 16; i++) begin
         w = s ? i[3:0] : {i[0], i[1], i[2], i[3]};
         m = {m[30:0], 1'b0} ^ (m[31] ? `FUT_SIGNATURE_ACCUMULATOR_POLY : 32'h0) ^ fut_flash_model_inst.fut_word({2'b01, w});
      end
      return m;
   endfunction : expsig
   initial begin
      #160000;
      fails++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      bus(0, `FUT_REG_CTRL, 0); chk(rdv, 32'h1);
      bus(0, `FUT_REG_WAIT, 0); chk(rdv, 32'h5);
      bus(0, 3'h7, 0); chk(rdv, 32'h0);
      bus(1, `FUT_REG_CTRL, 32'h80000002); bus(0, `FUT_REG_CTRL, 0); chk(rdv, 32'h1);
      bus(1, `FUT_REG_CTRL, `FUT_PASSWORD); bus(0, `FUT_REG_CTRL, 0); chk(rdv, 32'h80000001);
      @(posedge clk) userRead <= 1'b1;
      @(posedge clk) userRead <= 1'b0;
      bus(0, `FUT_REG_STAT, 0); chk(rdv & 32'h1, 32'h1);
      bus(1, `FUT_REG_STAT, 32'h1); bus(0, `FUT_REG_STAT, 0); chk(rdv & 32'h1, 32'h0);
      // block 0 selected but locked, the rest unselected: seeds must survive
      bus(1, `FUT_REG_BSEL, 32'h1);
      bus(1, `FUT_REG_SIG0, 32'h5eed0001);
      bus(1, `FUT_REG_SIG1, 32'h5eed0002);
      bus(1, `FUT_REG_CTRL, 32'h80000002); waitdone(400);
      bus(0, `FUT_REG_SIG0, 0); chk(rdv, 32'h5eed0001);
      bus(0, `FUT_REG_SIG1, 0); chk(rdv, 32'h5eed0002);
      bus(1, `FUT_REG_CTRL, 32'h80000000);
      blockLocked <= 4'h0;
      bus(1, `FUT_REG_BSEL, 32'h2);
      for (int s = 0; s < 2; s++) begin
         bus(1, `FUT_REG_SIG0, 0);
         bus(1, `FUT_REG_CTRL, 32'h80000002 | (s << 2));
         bus(1, `FUT_REG_SIG0, 32'hffffffff);
         bus(0, `FUT_REG_SIG0, 0); chk(rdv, 32'h0);
         waitdone(400);
         bus(0, `FUT_REG_SIG0, 0); chk(rdv, expsig(s[0]));
         bus(1, `FUT_REG_CTRL, 32'h80000000 | (s << 2));
      end
      for (int m = 0; m < 2; m++) begin
         b = m ? 32'h80000030 : 32'h80000000;
         if (m) bus(1, `FUT_REG_CTRL, 32'h80000020);
         bus(1, `FUT_REG_CTRL, b);
         @(posedge clk);
         @(negedge clk) chk({30'h0, marginEn, marginLevel}, m ? 32'h3 : 32'h0);
         bus(1, `FUT_REG_CTRL, b | 32'h2);
         bus(1, `FUT_REG_CTRL, b);
         waitdone(4);
      end
      bus(1, `FUT_REG_CTRL, 32'h0);
      @(posedge clk);
      @(negedge clk) chk({29'h0, marginEn, marginLevel, testActive}, 32'h0);
      bus(1, `FUT_REG_CTRL, `FUT_PASSWORD);
      bus(1, `FUT_REG_FDATA, 32'h55555555);
      bus(1, `FUT_REG_CTRL, 32'h80380000);
      bus(1, `FUT_REG_CTRL, 32'h80380008);
      bus(1, `FUT_REG_CTRL, 32'h8038000a);
      waitdone(4);
      bus(0, `FUT_REG_SIG1, 0); chk(rdv & 32'h1ff, 32'h0b8);
      tally_and_finish();
   end
endmodule : flash_user_test_signature_accumulator_engine_bench
bind fut_engine fut_engine_sva fut_engine_sva_inst (.clk, .srst, .avsRead, .avsWrite, .avsReaddata,
   .avsWaitrequest, .arrRead, .arrAddr, .marginEn, .blockLocked, .testActive);
